// >>> slt_pkg.sv
// Purpose: Shared constants for the SYSREF, LMFC and timestamp block.
// Assumes: APB with 32-bit data; register index times four gives the byte address.
// Notes: Only the low eight bits of each register word are used.
package slt_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [10:0] IDX_CAPTURE = 11'h120;
  localparam logic [10:0] IDX_TS_DELAY = 11'h123;
  localparam logic [10:0] IDX_MONITOR = 11'h128;
  localparam logic [10:0] IDX_SYNC_MODE = 11'h1FF;
  localparam logic [10:0] IDX_CB_FUNC_LO = 11'h559;
  localparam logic [10:0] IDX_CB_FUNC_HI = 11'h55A;
  localparam logic [10:0] IDX_LMFC_OFS = 11'h578;
  localparam logic [10:0] IDX_CB_COUNT = 11'h58F;
  localparam logic [10:0] IDX_SUBCLASS = 11'h590;
  localparam int ADDR_W = 13;
  localparam int IDX_LSB = 2;
  // Reset values.
  localparam logic [7:0] RST_SUBCLASS = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Field positions.
  localparam int SC_LSB = 5;
  localparam int POL_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int MODE_LSB = 1;
  localparam int CS_LSB = 6;
  localparam int OFS_W = 5;
  // Field codes.
  localparam logic [2:0] SC_ZERO = 3'h0;
  localparam logic [2:0] SC_ONE = 3'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_NSHOT = 2'h2;
  localparam logic [3:0] FUNC_SYSREF = 4'h5;
  localparam logic [4:0] F_ONE = 5'h01;
  localparam logic [4:0] F_TWO = 5'h02;
  localparam logic [3:0] NIB_MAX = 4'hF;
  // Sample widths and the pipeline depth matching the SYSREF synchroniser.
  localparam int SMP_W = 14;
  localparam int OUT_W = 16;
  localparam int PIPE_D = 3;
endpackage : slt_pkg

// >>> slt_sync_core.sv
// Purpose: SYSREF capture, LMFC alignment and sample timestamping for a JESD204B transmitter.
// Assumes: One clk_sys cycle is one sample and one frame clock period.
// Notes: Registers are reached over APB with zero wait states.
// How it works
// - Subclass field resets to Subclass 1.
// - Subclass 0 runs without any SYSREF.
// - LMFC edge marks each multiframe start.
// - Subclass 1 SYSREF realigns LMFC and dividers.
// - Five-bit offset delays the LMFC phase.
// - F of one: steps of four frames.
// - F of two: steps of two frames.
// - Other F: one frame per step.
// - Readable setup and hold margin status.
// - Bit selects rising or falling SYSREF transition.
// - Bit selects capture clock edge.
// - Sync mode resets to normal alignment.
// - Timestamp mode marks sample, no clock reset.
// - Function code five routes timestamp to bit.
// - Delay setting shifts which sample is marked.
// - No marking while decimation is used.
// - Both channels share identical pipeline latency.
// - Mode field: continuous, or self-clearing N-shot.
// - Monitor: hold high nibble, setup low.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module slt_sync_core
  import slt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SYSREF pin and link setup.
  input wire logic sysref,
  input wire logic [4:0] frame_octets,
  input wire logic [5:0] mf_frames,
  input wire logic decim_active,
  // Sample stream.
  input wire logic [SMP_W-1:0] smp_a,
  input wire logic [SMP_W-1:0] smp_b,
  output logic [OUT_W-1:0] out_a,
  output logic [OUT_W-1:0] out_b,
  // Clock alignment outputs.
  output logic lmfc_pulse,
  output logic div_sync
);

  // Register storage.
  logic [7:0] capture_ctl;
  logic [7:0] ts_delay;
  logic [7:0] monitor;
  logic [7:0] sync_mode;
  logic [7:0] cb_func_lo;
  logic [7:0] cb_func_hi;
  logic [7:0] lmfc_ofs;
  logic [7:0] cb_count;
  logic [7:0] subclass_sel;

  // Decoded fields.
  logic [2:0] subclass;
  logic [1:0] sr_mode;
  logic ts_mode;
  logic [1:0] cs;
  assign subclass = subclass_sel[SC_LSB +: 3];
  assign sr_mode = capture_ctl[MODE_LSB +: 2];
  assign ts_mode = sync_mode[0];
  assign cs = cb_count[CS_LSB +: 2];

  // APB decode.
  logic [10:0] idx;
  logic wr_en;
  logic acc;
  logic hit;
  logic ro;
  assign idx = paddr[ADDR_W-1:IDX_LSB];
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && hit && !ro;
  // Zero wait states keep the master's wait short and fixed.
  assign pready = 1'b1;

  // Address map lookup; unmapped word addresses flag an error.
  always_comb begin
    hit = 1'b1;
    ro = 1'b0;
    prdata = 32'h0000_0000;
    if (paddr[IDX_LSB-1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == IDX_CAPTURE) begin
      prdata[7:0] = capture_ctl;
    end else if (idx == IDX_TS_DELAY) begin
      prdata[7:0] = ts_delay;
    end else if (idx == IDX_MONITOR) begin
      prdata[7:0] = monitor;
      ro = 1'b1;
    end else if (idx == IDX_SYNC_MODE) begin
      prdata[7:0] = sync_mode;
    end else if (idx == IDX_CB_FUNC_LO) begin
      prdata[7:0] = cb_func_lo;
    end else if (idx == IDX_CB_FUNC_HI) begin
      prdata[7:0] = cb_func_hi;
    end else if (idx == IDX_LMFC_OFS) begin
      prdata[7:0] = lmfc_ofs;
    end else if (idx == IDX_CB_COUNT) begin
      prdata[7:0] = cb_count;
    end else if (idx == IDX_SUBCLASS) begin
      prdata[7:0] = subclass_sel;
    end else begin
      hit = 1'b0;
    end
    if (!hit) begin
      prdata = 32'h0000_0000;
    end
  end

  // Unmapped addresses and writes to the monitor answer with an error.
  assign pslverr = acc && (!hit || (pwrite && ro));

  // SYSREF synchroniser; the first stage feeds only the second.
  logic sr_m;
  logic sr_s;
  logic sr_d1;
  logic sr_d2;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sr_m <= 1'b0;
      sr_s <= 1'b0;
      sr_d1 <= 1'b0;
      sr_d2 <= 1'b0;
    end else begin
      sr_m <= sysref;
      sr_s <= sr_m;
      sr_d1 <= sr_s;
      sr_d2 <= sr_d1;
    end
  end

  // capture edge: the alternate edge is taken one stage later.
  logic cur;
  logic prv;
  assign cur = capture_ctl[EDGE_BIT] ? sr_d1 : sr_s;
  assign prv = capture_ctl[EDGE_BIT] ? sr_d2 : sr_d1;

  // transition select: high-to-low when the bit is set.
  logic trans;
  assign trans = capture_ctl[POL_BIT] ? (prv && !cur) : (!prv && cur);

  // A transition counts only while the mode field arms the capture.
  logic sr_event;
  assign sr_event = trans && (sr_mode != MODE_OFF);

  // N-shot self clear; a software write in the same cycle wins so it can re-arm.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      capture_ctl <= RST_ZERO;
    end else if (wr_en && idx == IDX_CAPTURE) begin
      capture_ctl <= pwdata[7:0];
    end else if (sr_event && sr_mode == MODE_NSHOT) begin
      capture_ctl[MODE_LSB +: 2] <= MODE_OFF;
    end
  end

  // Remaining writable registers; subclass and mode reset values.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ts_delay <= RST_ZERO;
      sync_mode <= RST_ZERO;
      cb_func_lo <= RST_ZERO;
      cb_func_hi <= RST_ZERO;
      lmfc_ofs <= RST_ZERO;
      cb_count <= RST_ZERO;
      subclass_sel <= RST_SUBCLASS;
    end else if (wr_en) begin
      if (idx == IDX_TS_DELAY) begin
        ts_delay <= pwdata[7:0];
      end else if (idx == IDX_SYNC_MODE) begin
        sync_mode <= pwdata[7:0];
      end else if (idx == IDX_CB_FUNC_LO) begin
        cb_func_lo <= pwdata[7:0];
      end else if (idx == IDX_CB_FUNC_HI) begin
        cb_func_hi <= pwdata[7:0];
      end else if (idx == IDX_LMFC_OFS) begin
        lmfc_ofs <= pwdata[7:0];
      end else if (idx == IDX_CB_COUNT) begin
        cb_count <= pwdata[7:0];
      end else if (idx == IDX_SUBCLASS) begin
        subclass_sel <= pwdata[7:0];
      end
    end
  end

  // Setup and hold margin counters: cycles SYSREF held before and after an edge.
  logic [3:0] stable_cnt;
  logic [3:0] setup_held;
  logic hold_run;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stable_cnt <= 4'h0;
      setup_held <= 4'h0;
      hold_run <= 1'b0;
      monitor <= RST_ZERO;
    end else if (sr_s != sr_d1) begin
      // A transition closes the setup window and opens the hold window.
      stable_cnt <= 4'h0;
      setup_held <= stable_cnt;
      hold_run <= 1'b1;
    end else begin
      if (stable_cnt != NIB_MAX) begin
        stable_cnt <= stable_cnt + 4'h1;
      end
      // status nibbles, hold high and setup low.
      if (hold_run) begin
        monitor <= {stable_cnt, setup_held};
        if (stable_cnt == NIB_MAX) begin
          hold_run <= 1'b0;
        end
      end
    end
  end

  // normal mode realigns in Subclass 1; Subclass 0 never does.
  logic realign;
  assign realign = sr_event && (subclass == SC_ONE) && !ts_mode;

  // Divider realign pulse for the sample dividers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_sync <= 1'b0;
    end else begin
      div_sync <= realign;
    end
  end

  // offset step scaled by F; invalid low bits are dropped.
  logic [OFS_W-1:0] ofs_frames;
  always_comb begin
    if (frame_octets == F_ONE) begin
      ofs_frames = {lmfc_ofs[4:2], 2'b00};
    end else if (frame_octets == F_TWO) begin
      ofs_frames = {lmfc_ofs[4:1], 1'b0};
    end else begin
      ofs_frames = lmfc_ofs[OFS_W-1:0];
    end
  end

  // frame counter over one multiframe, reset to phase zero by SYSREF.
  logic [4:0] frame_cnt;
  logic [4:0] last_frame;
  assign last_frame = 5'(mf_frames - 6'h01);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_cnt <= 5'h00;
    end else if (realign || frame_cnt == last_frame) begin
      frame_cnt <= 5'h00;
    end else begin
      frame_cnt <= frame_cnt + 5'h01;
    end
  end

  // LMFC edge placed at the offset frame within each multiframe.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lmfc_pulse <= 1'b0;
    end else begin
      lmfc_pulse <= !realign && (frame_cnt == ofs_frames);
    end
  end

  // timestamp delay countdown from the captured event.
  logic [7:0] ts_cnt;
  logic ts_wait;
  logic ts_hit;
  assign ts_hit = ts_mode && ((sr_event && ts_delay == RST_ZERO)
                  || (ts_wait && ts_cnt == 8'h01));
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ts_cnt <= 8'h00;
      ts_wait <= 1'b0;
    end else if (ts_mode && sr_event && ts_delay != RST_ZERO) begin
      ts_cnt <= ts_delay;
      ts_wait <= 1'b1;
    end else if (ts_wait) begin
      ts_cnt <= ts_cnt - 8'h01;
      ts_wait <= (ts_cnt != 8'h01);
    end
  end

  // marks are suppressed whenever decimation is in use.
  logic mark;
  assign mark = ts_hit && !decim_active;

  // control bit routing by function code and enabled count.
  logic [2:0] cb;
  always_comb begin
    cb[0] = mark && cs >= 2'd1 && cb_func_lo[3:0] == FUNC_SYSREF;
    cb[1] = mark && cs >= 2'd2 && cb_func_lo[7:4] == FUNC_SYSREF;
    cb[2] = mark && cs == 2'd3 && cb_func_hi[3:0] == FUNC_SYSREF;
  end

  // two delay lines of equal depth so both channels see equal latency.
  logic [SMP_W-1:0] pipe_a [PIPE_D];
  logic [SMP_W-1:0] pipe_b [PIPE_D];
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_D; i++) begin
        pipe_a[i] <= '0;
        pipe_b[i] <= '0;
      end
    end else begin
      pipe_a[0] <= smp_a;
      pipe_b[0] <= smp_b;
      for (int i = 1; i < PIPE_D; i++) begin
        pipe_a[i] <= pipe_a[i-1];
        pipe_b[i] <= pipe_b[i-1];
      end
    end
  end

  // output words carry the mark in the low control bits.
  // With three control bits, bit 2 replaces the sample LSB.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_a <= '0;
      out_b <= '0;
    end else begin
      out_a <= {pipe_a[PIPE_D-1], cb[1:0]};
      out_b <= {pipe_b[PIPE_D-1], cb[1:0]};
      if (cs == 2'd3) begin
        out_a[2] <= cb[2];
        out_b[2] <= cb[2];
      end
    end
  end

  // Checks on the logic above.
  chk_sc_reset: assert property (@(posedge clk_sys)
    $past(!rst_n) && rst_n |-> subclass == SC_ONE && !ts_mode)
    else $error("subclass or sync mode wrong after reset");
  chk_sc0_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    subclass == SC_ZERO |=> !div_sync)
    else $error("divider realign in subclass 0");
  chk_mf_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_cnt == last_frame && !realign |=> frame_cnt == 5'h00)
    else $error("frame counter failed to wrap");
  chk_realign_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
    realign |=> div_sync && frame_cnt == 5'h00 && !lmfc_pulse)
    else $error("SYSREF did not realign");
  chk_lmfc_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lmfc_pulse |-> $past(frame_cnt) == $past(ofs_frames))
    else $error("LMFC edge off phase");
  chk_f1_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_octets == F_ONE |-> ofs_frames[1:0] == 2'b00)
    else $error("F=1 offset not multiple of four");
  chk_f2_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_octets == F_TWO |-> ofs_frames[0] == 1'b0)
    else $error("F=2 offset not even");
  chk_pol_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sr_mode != MODE_OFF && !capture_ctl[EDGE_BIT] && !capture_ctl[POL_BIT]
    && $rose(sr_s) |-> sr_event)
    else $error("rising SYSREF not captured");
  chk_ts_noreset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ts_mode && sr_event |=> !div_sync)
    else $error("timestamp mode reset clocks");
  chk_ts_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ts_mode && sr_event && ts_delay == 8'h03 && !wr_en |-> ##3 ts_hit)
    else $error("timestamp delay wrong");
  chk_no_decim: assert property (@(posedge clk_sys) disable iff (!rst_n)
    decim_active |-> !mark)
    else $error("mark during decimation");
  chk_nshot_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sr_event && sr_mode == MODE_NSHOT && !wr_en |=> sr_mode == MODE_OFF)
    else $error("N-shot did not clear");
  cov_realign: cover property (@(posedge clk_sys) disable iff (!rst_n) realign);
  cov_mark: cover property (@(posedge clk_sys) disable iff (!rst_n) cb[0]);
  cov_nshot: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sr_event && sr_mode == MODE_NSHOT);

endmodule : slt_sync_core
`default_nettype wire

// >>> slt_rx_model.sv
// Purpose: Receiver-side model that picks timestamp marks off the sample stream.
// Assumes: Each output word is {sample, cb1, cb0} with two control bits enabled.
// Notes: It only observes; the stream has no back-pressure to model.
`timescale 1ns/10ps
`default_nettype none
module slt_rx_model
  import slt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Stream from the transmitter.
  input wire logic [OUT_W-1:0] out_a,
  input wire logic [OUT_W-1:0] out_b,
  input wire logic lmfc_pulse,
  // Findings for the bench.
  output logic [SMP_W-1:0] mk_a,
  output logic [SMP_W-1:0] mk_b,
  output logic [1:0] mk_bits,
  output var int mk_cnt,
  output var int lmfc_cnt
);
  // decode timestamp bits
  // Both lanes are captured together, so a skew between channels shows up.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mk_cnt <= 0;
    end else if (out_a[1:0] != 2'h0) begin
      mk_a <= out_a[OUT_W-1:2];
      mk_b <= out_b[OUT_W-1:2];
      mk_bits <= out_a[1:0];
      mk_cnt <= mk_cnt + 1;
    end
  end

  // Multiframe edges are counted to check the framing period.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lmfc_cnt <= 0;
    end else if (lmfc_pulse) begin
      lmfc_cnt <= lmfc_cnt + 1;
    end
  end
endmodule : slt_rx_model
`default_nettype wire

// >>> test_sysref_lmfc_sync_timestamp.sv
// Purpose: Self-checking bench for the SYSREF, LMFC and timestamp block.
// Assumes: APB answers at once; one clock is one frame and one sample.
// Notes: Timing checks use differences, so fixed pipe stages cancel out.
`timescale 1ns/10ps
`default_nettype none
module test_sysref_lmfc_sync_timestamp
  import slt_pkg::*;
;
  logic clk_sys, rst_n, psel, penable, pwrite, sysref, decim_active, pready, pslverr;
  logic lmfc_pulse, div_sync, got;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] frame_octets;
  logic [5:0] mf_frames;
  logic [SMP_W-1:0] smp_a, smp_b, mk_a, mk_b;
  logic [OUT_W-1:0] out_a, out_b;
  logic [1:0] mk_bits;
  int mk_cnt, lmfc_cnt, err_total, compares, cyc, t_div, t_lm, t_last, per, n_div, t_up, t_dn;

  slt_sync_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref(sysref), .frame_octets(frame_octets), .mf_frames(mf_frames),
    .decim_active(decim_active), .smp_a(smp_a), .smp_b(smp_b), .out_a(out_a), .out_b(out_b),
    .lmfc_pulse(lmfc_pulse), .div_sync(div_sync));
  slt_rx_model rx_u (.clk_sys(clk_sys), .rst_n(rst_n), .out_a(out_a), .out_b(out_b),
    .lmfc_pulse(lmfc_pulse), .mk_a(mk_a), .mk_b(mk_b), .mk_bits(mk_bits), .mk_cnt(mk_cnt),
    .lmfc_cnt(lmfc_cnt));

  // Free-running 20 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Samples carry the cycle number, so a mark tells which sample it sits on.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    smp_a <= cyc[SMP_W-1:0];
    smp_b <= SMP_W'(cyc + 100);
    if (lmfc_pulse === 1'b1) begin
      per <= cyc - t_last;
      t_last <= cyc;
      if (!got) t_lm <= cyc;
      got <= 1'b1;
    end
    if (div_sync === 1'b1) begin
      t_div <= cyc;
      n_div <= n_div + 1;
      got <= 1'b0;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apb(input logic w, input logic [10:0] i, input logic [7:0] d,
                     output logic [31:0] q, output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [10:0] i, input logic [7:0] e, input logic ee);
    logic [31:0] q;
    logic er;
    apb(1'b0, i, 8'h00, q, er);
    chk(q, {24'h0, e}, "read data");
    chk({31'h0, er}, {31'h0, ee}, "read error flag");
  endtask : rd

  task automatic wr(input logic [10:0] i, input logic [7:0] d, input logic ee);
    logic [31:0] q;
    logic er;
    apb(1'b1, i, d, q, er);
    chk({31'h0, er}, {31'h0, ee}, "write error flag");
  endtask : wr

  // One SYSREF pulse, long enough that both monitor nibbles saturate.
  task automatic sr();
    @(posedge clk_sys);
    sysref <= 1'b1;
    t_up = cyc;
    repeat (30) @(posedge clk_sys);
    sysref <= 1'b0;
    t_dn = cyc;
    repeat (30) @(posedge clk_sys);
  endtask : sr

  task automatic t_regs();
    rd(IDX_SUBCLASS, RST_SUBCLASS, 1'b0);
    rd(IDX_SYNC_MODE, RST_ZERO, 1'b0);
    rd(11'h7FF, 8'h00, 1'b1);
    wr(IDX_MONITOR, 8'hFF, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_edges();
    int lat;
    wr(IDX_CAPTURE, 8'h02, 1'b0);
    sr();
    lat = t_div - t_up;
    chk(n_div, 1, "realign count");
    chk(per, mf_frames, "multiframe period");
    rd(IDX_CAPTURE, 8'h02, 1'b0);
    rd(IDX_MONITOR, 8'hFF, 1'b0);
    wr(IDX_CAPTURE, 8'h0A, 1'b0);
    sr();
    chk(t_div - t_up, lat + 1, "clock edge stage");
    wr(IDX_CAPTURE, 8'h12, 1'b0);
    sr();
    chk(t_div - t_dn, lat, "falling event time");
    chk(n_div, 3, "rise ignored");
    $display("test edges done");
  endtask : t_edges

  task automatic offs(input logic [4:0] f, input logic [7:0] w, input int e);
    int base;
    frame_octets <= f;
    wr(IDX_LMFC_OFS, 8'h00, 1'b0);
    sr();
    base = t_lm - t_div;
    wr(IDX_LMFC_OFS, w, 1'b0);
    sr();
    chk(t_lm - t_div - base, e, "lmfc shift");
  endtask : offs

  task automatic t_offset();
    wr(IDX_CAPTURE, 8'h02, 1'b0);
    offs(5'h01, 8'h05, 4);
    offs(5'h02, 8'h05, 4);
    offs(5'h04, 8'h05, 5);
    $display("test offset done");
  endtask : t_offset

  task automatic t_nshot();
    int n;
    wr(IDX_CAPTURE, 8'h04, 1'b0);
    n = n_div;
    sr();
    sr();
    rd(IDX_CAPTURE, 8'h00, 1'b0);
    chk(n_div, n + 1, "single shot");
    $display("test nshot done");
  endtask : t_nshot

  task automatic t_stamp();
    int n, base;
    wr(IDX_SYNC_MODE, 8'h01, 1'b0);
    wr(IDX_CB_COUNT, 8'h80, 1'b0);
    wr(IDX_CB_FUNC_LO, 8'h05, 1'b0);
    wr(IDX_CAPTURE, 8'h02, 1'b0);
    n = n_div;
    sr();
    chk(mk_cnt, 1, "one mark");
    chk(n_div, n, "no clock reset");
    chk(mk_bits, 2'h1, "mark on bit 0");
    chk(mk_b - mk_a, 100, "channel skew");
    base = mk_a - t_up;
    wr(IDX_TS_DELAY, 8'h03, 1'b0);
    sr();
    chk(mk_a - t_up - base, 3, "mark delay");
    wr(IDX_CB_FUNC_LO, 8'h50, 1'b0);
    sr();
    chk(mk_bits, 2'h2, "mark on bit 1");
    decim_active <= 1'b1;
    n = mk_cnt;
    sr();
    chk(mk_cnt, n, "no mark when decimating");
    decim_active <= 1'b0;
    $display("test stamp done");
  endtask : t_stamp

  task automatic t_sub0();
    int n;
    wr(IDX_SUBCLASS, 8'h00, 1'b0);
    wr(IDX_SYNC_MODE, 8'h00, 1'b0);
    n = lmfc_cnt;
    repeat (32) @(posedge clk_sys);
    chk(lmfc_cnt - n, 4, "lmfc without sysref");
    n = n_div;
    sr();
    chk(n_div, n, "realign in subclass 0");
    $display("test subclass0 done");
  endtask : t_sub0

  task automatic conclude();
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence; reset is held for eight cycles first.
  initial begin
    {psel, penable, pwrite, sysref, decim_active, rst_n, got} = 7'h00;
    paddr = 13'h0;
    pwdata = 32'h0;
    frame_octets = 5'h04;
    mf_frames = 6'h08;
    {cyc, n_div, t_div, t_lm, t_last, per, err_total, compares} = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_edges();
    t_offset();
    t_nshot();
    t_stamp();
    t_sub0();
    conclude();
  end

  // Watchdog; the whole run needs well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule : test_sysref_lmfc_sync_timestamp
`default_nettype wire
